// ===== otp_pkg.sv
// Package of constants and types for the ODT power-down transition link
package otp_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned ASYNC_MIN_PS = 2000;
  localparam int unsigned ASYNC_MAX_PS = 8500;
  localparam logic [4:0] ASYNC_MIN_CYC = 5'(((ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS));
  localparam logic [4:0] ASYNC_MAX_CYC_RAW = 5'((ASYNC_MAX_PS / CLK_PERIOD_PS));
  localparam logic [4:0] ASYNC_MAX_CYC = (ASYNC_MAX_CYC_RAW == 5'h00) ? 5'h01 : ASYNC_MAX_CYC_RAW;
  localparam logic [4:0] AON_MIN_CYC = 5'h00;
  localparam logic [4:0] AON_MAX_CYC = 5'h01;
  localparam logic [4:0] ODTL_SUB = 5'h02;
  localparam logic [4:0] ANPD_SUB = 5'h01;
  localparam logic [4:0] XPDLL_CYC = 5'h0a;
  localparam logic [7:0] RFC_CYC = 8'h40;

  // ==========================================================
  // Reset values
  localparam logic [3:0] CWL_RST = 4'h9;
  localparam logic [3:0] AL_RST = 4'h0;

  // ==========================================================
  // Field widths
  localparam int unsigned LAT_W = 5;
  localparam int unsigned CNT_W = 8;

  typedef enum logic [1:0] {
    OTP_SYNC,
    OTP_TRANS,
    OTP_ASYNC
  } otp_mode_t;

endpackage : otp_pkg

// ===== otp_if.sv
// Interface carrying CKE, ODT and refresh strobes between controller and memory
`timescale 1ns/100ps
interface otp_if;
  logic cke;
  logic odt;
  logic refresh;
  logic dll_off_pd;
  logic [3:0] cwl;
  logic [3:0] al;

  modport ctrl (output cke, output odt, output refresh, output dll_off_pd, output cwl,
    output al);
  modport mem (input cke, input odt, input refresh, input dll_off_pd, input cwl, input al);
endinterface : otp_if

// ===== otp_mem_end.sv
// Memory end: tracks ODT transition windows and drives the termination state
`timescale 1ns/100ps
module otp_mem_end
  import otp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  otp_if.mem link,
  output logic rtt_on,
  output logic in_window,
  output logic async_mode,
  output logic [LAT_W-1:0] odtl_cyc,
  output logic [LAT_W-1:0] anpd_cyc
);

  typedef struct packed {
    logic cke_prev;
    logic odt_prev;
    logic rtt;
    logic pend;
    logic pend_val;
    logic [LAT_W-1:0] dly;
    logic [CNT_W-1:0] win_cnt;
    logic [CNT_W-1:0] ref_cnt;
    otp_mode_t mode;
  } otp_mem_st_t;

  otp_mem_st_t s_q;
  otp_mem_st_t s_d;
  logic [LAT_W-1:0] wl;

  // ==========================================================
  // Derived latencies
  assign wl = LAT_W'(link.cwl) + LAT_W'(link.al);
  assign odtl_cyc = wl - ODTL_SUB;
  assign anpd_cyc = wl - ANPD_SUB;

  // ==========================================================
  // Next state
  always_comb begin
    logic cke_fall;
    logic cke_rise;
    logic odt_chg;
    logic [LAT_W-1:0] sync_dly;
    logic [LAT_W-1:0] sync_max;
    cke_fall = 1'b0;
    cke_rise = 1'b0;
    odt_chg = 1'b0;
    sync_dly = '0;
    sync_max = '0;
    s_d = s_q;
    cke_fall = s_q.cke_prev && !link.cke;
    cke_rise = !s_q.cke_prev && link.cke;
    odt_chg = link.odt != s_q.odt_prev;
    s_d.cke_prev = link.cke;
    s_d.odt_prev = link.odt;
    if (link.refresh) begin
      s_d.ref_cnt = RFC_CYC;
    end else if (s_q.ref_cnt != '0) begin
      s_d.ref_cnt = s_q.ref_cnt - 8'h01;
    end
    if (s_q.win_cnt != '0) begin
      s_d.win_cnt = s_q.win_cnt - 8'h01;
    end
    case (s_q.mode)
      OTP_SYNC: begin
        // Entry window opens on the CKE fall itself; held until refresh done
        if (cke_fall && link.dll_off_pd) begin
          s_d.mode = OTP_TRANS;
          s_d.win_cnt = s_q.ref_cnt;
        end
      end
      OTP_TRANS: begin
        if (cke_rise) begin
          s_d.win_cnt = CNT_W'(XPDLL_CYC);
        end else if (s_q.win_cnt == '0 || (s_q.win_cnt == 8'h01 && !link.cke)) begin
          s_d.mode = link.cke ? OTP_SYNC : OTP_ASYNC;
        end
      end
      OTP_ASYNC: begin
        if (cke_rise) begin
          s_d.mode = OTP_TRANS;
          s_d.win_cnt = CNT_W'(XPDLL_CYC);
        end
      end
      default: begin
        s_d.mode = OTP_SYNC;
      end
    endcase
    // Response delay for an ODT edge
    sync_dly = odtl_cyc + (link.odt ? AON_MIN_CYC : AON_MIN_CYC);
    sync_max = odtl_cyc + AON_MAX_CYC;
    if (odt_chg) begin
      s_d.pend = 1'b1;
      s_d.pend_val = link.odt;
      case (s_q.mode)
        OTP_ASYNC: s_d.dly = ASYNC_MIN_CYC;
        OTP_TRANS: begin
          // Take latest legal point inside the min and max envelope
          s_d.dly = (ASYNC_MAX_CYC > sync_max) ? ASYNC_MAX_CYC : sync_max;
        end
        default: s_d.dly = (sync_dly < 5'h01) ? 5'h01 : sync_dly;
      endcase
    end else if (s_q.pend) begin
      if (s_q.dly <= 5'h01) begin
        s_d.pend = 1'b0;
        s_d.rtt = s_q.pend_val;
      end else begin
        s_d.dly = s_q.dly - 5'h01;
      end
    end
    if (!nrst) begin
      s_d = '0;
      s_d.mode = OTP_SYNC;
      s_d.cke_prev = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en || !nrst) begin
      s_q <= s_d;
    end
  end

  assign rtt_on = s_q.rtt;
  assign in_window = s_q.mode == OTP_TRANS;
  assign async_mode = s_q.mode == OTP_ASYNC;

endmodule : otp_mem_end

// ===== otp_ctrl_end.sv
// Controller end: drives CKE, ODT and refresh, tracking the transition windows
`timescale 1ns/100ps
module otp_ctrl_end
  import otp_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic pd_req,
  input wire logic odt_req,
  input wire logic refresh_req,
  input wire logic dll_off_cfg,
  input wire logic [3:0] cwl_cfg,
  input wire logic [3:0] al_cfg,
  otp_if.ctrl link,
  output logic odt_blocked,
  output logic window_busy
);

  typedef struct packed {
    logic cke;
    logic odt;
    logic refresh;
    logic [CNT_W-1:0] hold;
    logic [CNT_W-1:0] ref_cnt;
  } otp_ctrl_st_t;

  otp_ctrl_st_t s_q;
  otp_ctrl_st_t s_d;
  logic [LAT_W-1:0] anpd;

  assign anpd = LAT_W'(cwl_cfg) + LAT_W'(al_cfg) - ANPD_SUB;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.refresh = 1'b0;
    if (s_q.hold != '0) begin
      s_d.hold = s_q.hold - 8'h01;
    end
    if (s_q.ref_cnt != '0) begin
      s_d.ref_cnt = s_q.ref_cnt - 8'h01;
    end
    if (refresh_req && s_q.cke && s_q.hold == '0 && s_q.ref_cnt == '0) begin
      s_d.refresh = 1'b1;
      s_d.ref_cnt = RFC_CYC;
    end else if (s_q.hold == '0 && pd_req != !s_q.cke) begin
      // Each CKE edge holds ODT still across the window
      s_d.cke = !pd_req;
      s_d.hold = CNT_W'(anpd) + (pd_req ? s_q.ref_cnt : CNT_W'(XPDLL_CYC));
    end
    // ODT never moves on the same edge as CKE, so the memory sees it settled
    if (s_q.hold == '0 && s_d.cke == s_q.cke) begin
      s_d.odt = odt_req;
    end
    if (!nrst) begin
      s_d = '0;
      s_d.cke = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en || !nrst) begin
      s_q <= s_d;
    end
  end

  assign link.cke = s_q.cke;
  assign link.odt = s_q.odt;
  assign link.refresh = s_q.refresh;
  assign link.dll_off_pd = dll_off_cfg;
  assign link.cwl = cwl_cfg;
  assign link.al = al_cfg;
  assign odt_blocked = s_q.hold != '0;
  assign window_busy = s_q.hold != '0;

endmodule : otp_ctrl_end

// ===== otp_link_asserts.sv
// Checker of link timing between controller and memory ends
`timescale 1ns/100ps
module otp_link_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cke,
  input wire logic odt,
  input wire logic refresh,
  input wire logic dll_off_pd
);
  // ========
  // Steps
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence pd_in;
    $fell(cke) && dll_off_pd;
  endsequence
  sequence pd_out;
    $rose(cke) && dll_off_pd;
  endsequence
  // ========
  // Checks
  chk_reset_idle: assert property (disable iff (1'b0) !nrst |=> cke && !odt && !refresh)
    else $error("link not idle after reset");
  chk_refresh_pulse: assert property (refresh |=> !refresh)
    else $error("refresh strobe too long");
  chk_refresh_active: assert property (refresh |-> cke)
    else $error("refresh in power-down");
  chk_exit_hold: assert property (pd_out |=> cke [*8])
    else $error("cke dropped inside exit window");
  chk_exit_odt_quiet: assert property (pd_out |=> $stable(odt) [*8])
    else $error("odt moved inside exit window");
  chk_entry_hold: assert property (pd_in |=> !cke [*3])
    else $error("cke raised inside entry window");
  chk_entry_odt_quiet: assert property (pd_in |=> $stable(odt) [*3])
    else $error("odt moved inside entry window");
  chk_entry_odt_prior: assert property (pd_in |-> $stable(odt))
    else $error("odt moved at entry");
endmodule : otp_link_asserts

// ===== tb_odt_powerdown_transition.sv
// Testbench joining the controller and memory ends over the link
`timescale 1ns/100ps
module tb_odt_powerdown_transition;
  import otp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pd_req = 1'b0;
  logic odt_req = 1'b0;
  logic refresh_req = 1'b0;
  logic dll_off_cfg = 1'b1;
  logic [3:0] cwl_cfg = CWL_RST;
  logic [3:0] al_cfg = AL_RST;
  logic rtt_on, in_window, async_mode, odt_blocked, window_busy;
  logic [LAT_W-1:0] odtl_cyc, anpd_cyc;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 32'h691775bf;
  otp_if link ();
  always #12.5 clk = ~clk;
  otp_ctrl_end otp_ctrl_end_inst (.clk(clk), .nrst(nrst), .clk_en(1'b1), .pd_req(pd_req),
    .odt_req(odt_req), .refresh_req(refresh_req), .dll_off_cfg(dll_off_cfg),
    .cwl_cfg(cwl_cfg), .al_cfg(al_cfg), .link(link), .odt_blocked(odt_blocked),
    .window_busy(window_busy));
  otp_mem_end otp_mem_end_inst (.clk(clk), .nrst(nrst), .clk_en(1'b1), .link(link),
    .rtt_on(rtt_on), .in_window(in_window), .async_mode(async_mode), .odtl_cyc(odtl_cyc),
    .anpd_cyc(anpd_cyc));
  otp_link_asserts chk_inst (.clk(clk), .nrst(nrst), .cke(link.cke), .odt(link.odt),
    .refresh(link.refresh), .dll_off_pd(link.dll_off_pd));
  // ========
  // Helpers
  function automatic logic [4:0] lat(input logic [3:0] c, input logic [3:0] a,
    input logic [4:0] s);
    return 5'(c) + 5'(a) - s;
  endfunction : lat
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_lat(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_lat
  task automatic tally_and_finish;
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ========
  // Sequence
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 24; i++) begin
      // Leave power-down and let windows drain before touching the mode setup
      @(negedge clk);
      pd_req = 1'b0;
      refresh_req = 1'b0;
      repeat (100) @(negedge clk);
      cwl_cfg = (i == 0) ? 4'h5 : 4'(5 + $unsigned($random(seed)) % 9);
      al_cfg = (i == 0) ? 4'h0 : 4'($unsigned($random(seed)) % 8);
      dll_off_cfg = (i < 2) ? 1'(i) : 1'($random(seed));
      // Short CKE pulses with refresh among them
      repeat (6) begin
        @(negedge clk);
        pd_req = 1'($random(seed));
        refresh_req = 1'($random(seed));
        odt_req = 1'($random(seed));
        repeat ($unsigned($random(seed)) % 4) @(negedge clk);
      end
      @(negedge clk);
      pd_req = 1'($random(seed));
      refresh_req = 1'b0;
      odt_req = 1'($random(seed));
      repeat (200) @(negedge clk);
      cmp_lat(odtl_cyc, lat(cwl_cfg, al_cfg, 5'h02));
      cmp_lat(anpd_cyc, lat(cwl_cfg, al_cfg, 5'h01));
      cmp_bit(async_mode, pd_req & dll_off_cfg);
      cmp_bit(in_window, 1'b0);
      cmp_bit(rtt_on, odt_req);
      cmp_bit(link.cke, ~pd_req);
      cmp_bit(odt_blocked, 1'b0);
      cmp_bit(window_busy, 1'b0);
    end
    tally_and_finish();
  end
endmodule : tb_odt_powerdown_transition
